// [inc/acp_defines.svh]
// constants for the accumulator, coordinate and parameter command executor
//
// Summary of operation
// - instruction 39 stores accumulator into selected coordinate
// - global setting 84 selects volatile or nonvolatile coordinates
// - coordinate zero never goes to nonvolatile store
// - instruction 33 computes accumulator op x; types 0-7 write the result into accumulator
// - types 0-4 add, subtract, multiply, divide, modulo
// - types 5-7 and, or, xor; 8 inverts x
// - type 9 loads x; type 10 swaps
// - calculate ignores motor and value fields
// - instruction 34 writes accumulator to axis parameter
// - instruction 35 writes accumulator to global parameter
// - get coordinate: accumulator standalone, reply only direct
`ifndef ACP_DEFINES_SVH
`define ACP_DEFINES_SVH

// ----------------------------------------------------------------------
// datagram layout
// ----------------------------------------------------------------------
`define ACP_DG_LAST        4'h8

// ----------------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------------
`define ACP_I_GET_COORD    8'h1f
`define ACP_I_CALC_X       8'h21
`define ACP_I_ACCU_AXIS    8'h22
`define ACP_I_ACCU_GLOB    8'h23
`define ACP_I_ACCU_COORD   8'h27

// ----------------------------------------------------------------------
// calculate operation types
// ----------------------------------------------------------------------
`define ACP_OP_ADD         8'h00
`define ACP_OP_SUB         8'h01
`define ACP_OP_MUL         8'h02
`define ACP_OP_DIV         8'h03
`define ACP_OP_MOD         8'h04
`define ACP_OP_AND         8'h05
`define ACP_OP_OR          8'h06
`define ACP_OP_XOR         8'h07
`define ACP_OP_NOT         8'h08
`define ACP_OP_LOAD        8'h09
`define ACP_OP_SWAP        8'h0a

// ----------------------------------------------------------------------
// global settings and status codes
// ----------------------------------------------------------------------
`define ACP_GP_PERSIST     8'h54
`define ACP_GP_BANK        8'h00
`define ACP_ST_OK          8'h64
`define ACP_ST_BAD_CSUM    8'h01
`define ACP_ST_BAD_CMD     8'h02
`define ACP_ST_BAD_VAL     8'h04

`endif

// [inc/acp_pkg.sv]
// types shared by the command executor files
package acp_pkg;

    // ------------------------------------------------------------------
    // command, reply and transfer records
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  instr;
        logic [7:0]  ctype;
        logic [7:0]  motor;
        logic [31:0] value;
    } acp_cmd_t;

    typedef struct packed {
        logic [7:0]  status;
        logic [31:0] value;
    } acp_reply_t;

    typedef struct packed {
        logic [7:0]  num;
        logic [7:0]  bank;
        logic [31:0] data;
    } acp_pwr_t;

    typedef struct packed {
        logic [7:0]  motor;
        logic [7:0]  index;
        logic [31:0] data;
    } acp_coord_t;

endpackage

// [hw/acp_rx.sv]
// datagram assembler with address match and checksum check
`timescale 1ns/10ps
`include "acp_defines.svh"

module acp_rx
    import acp_pkg::*;
#(
    parameter logic [7:0] MODULE_ADDR = 8'h01
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // byte stream
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_byte,
    // assembled datagram
    output acp_cmd_t        dg_cmd,
    output logic            dg_valid,
    output logic            dg_ok
);
    logic [3:0] cnt_r,  cnt_nxt;
    logic [7:0] sum_r,  sum_nxt;
    logic [7:0] addr_r, addr_nxt;
    acp_cmd_t   cmd_r,  cmd_nxt;
    logic       val_r,  val_nxt;
    logic       ok_r,   ok_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        sum_nxt  = sum_r;
        addr_nxt = addr_r;
        cmd_nxt  = cmd_r;
        val_nxt  = 1'b0;
        ok_nxt   = ok_r;
        if (rx_valid) begin
            unique case (cnt_r)
                4'h0: addr_nxt = rx_byte;
                4'h1: cmd_nxt.instr = rx_byte;
                4'h2: cmd_nxt.ctype = rx_byte;
                4'h3: cmd_nxt.motor = rx_byte;
                4'h4, 4'h5, 4'h6, 4'h7: cmd_nxt.value = {cmd_r.value[23:0], rx_byte};
                default: begin
                    val_nxt = (addr_r == MODULE_ADDR);
                    ok_nxt  = (rx_byte == sum_r);
                end
            endcase
            sum_nxt = (cnt_r == `ACP_DG_LAST) ? 8'h00 : sum_r + rx_byte;
            cnt_nxt = (cnt_r == `ACP_DG_LAST) ? 4'h0 : cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r  <= 4'h0;
            sum_r  <= 8'h00;
            addr_r <= 8'h00;
            cmd_r  <= '0;
            val_r  <= 1'b0;
            ok_r   <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            sum_r  <= sum_nxt;
            addr_r <= addr_nxt;
            cmd_r  <= cmd_nxt;
            val_r  <= val_nxt;
            ok_r   <= ok_nxt;
        end
    end

    assign dg_cmd   = cmd_r;
    assign dg_valid = val_r;
    assign dg_ok    = ok_r;

    property p_frame_end;
        @(posedge clk) disable iff (!rst_n)
        dg_valid |-> $past(rx_valid) && ($past(cnt_r) == `ACP_DG_LAST) && (cnt_r == 4'h0);
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("datagram not nine bytes");

    property p_csum;
        @(posedge clk) disable iff (!rst_n)
        dg_valid |-> dg_ok == ($past(rx_byte) == $past(sum_r));
    endproperty
    a_csum: assert property (p_csum) else $error("checksum verdict wrong");
endmodule

// [hw/acp_alu.sv]
// eleven-operation calculate step on accumulator and x register
`timescale 1ns/10ps
`include "acp_defines.svh"

module acp_alu
    import acp_pkg::*;
(
    // operands
    input  wire logic [7:0]  op,
    input  wire logic [31:0] accu_in,
    input  wire logic [31:0] x_in,
    // results
    output logic [31:0]      accu_out,
    output logic [31:0]      x_out,
    output logic             op_ok
);
    logic signed [63:0] prod;

    always_comb begin
        accu_out = accu_in;
        x_out    = x_in;
        op_ok    = 1'b1;
        prod     = $signed(accu_in) * $signed(x_in);
        unique case (op)
            `ACP_OP_ADD: accu_out = accu_in + x_in;
            `ACP_OP_SUB: accu_out = accu_in - x_in;
            `ACP_OP_MUL: accu_out = prod[31:0];
            `ACP_OP_DIV, `ACP_OP_MOD: begin
                // division by zero leaves both registers alone
                if (x_in == 32'h0) begin
                    op_ok = 1'b0;
                end else if (op == `ACP_OP_DIV) begin
                    accu_out = 32'($signed(accu_in) / $signed(x_in));
                end else begin
                    accu_out = 32'($signed(accu_in) % $signed(x_in));
                end
            end
            `ACP_OP_AND: accu_out = accu_in & x_in;
            `ACP_OP_OR:  accu_out = accu_in | x_in;
            `ACP_OP_XOR: accu_out = accu_in ^ x_in;
            `ACP_OP_NOT: x_out = ~x_in;
            `ACP_OP_LOAD: x_out = accu_in;
            `ACP_OP_SWAP: begin
                accu_out = x_in;
                x_out    = accu_in;
            end
            default: op_ok = 1'b0;
        endcase
    end
endmodule

// [hw/acp_top.sv]
// command executor for accumulator, x register, coordinate and parameter moves
`timescale 1ns/10ps
`include "acp_defines.svh"

module acp_top
    import acp_pkg::*;
#(
    parameter logic [7:0] MODULE_ADDR = 8'h01,
    parameter int         N_MOTORS    = 1,
    parameter int         N_COORD     = 21
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // direct mode byte stream
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    // standalone program commands
    input  wire logic        prog_valid,
    input  wire acp_cmd_t    prog_cmd,
    output logic             prog_done,
    // direct mode reply
    output logic             reply_valid,
    output acp_reply_t       reply,
    // parameter writes
    output logic             axis_wr_valid,
    output acp_pwr_t         axis_wr,
    output logic             glob_wr_valid,
    output acp_pwr_t         glob_wr,
    // nonvolatile coordinate store
    output logic             nv_wr_valid,
    output acp_coord_t       nv_wr,
    input  wire logic        nv_ld_valid,
    input  wire acp_coord_t  nv_ld,
    // visible state
    output logic [31:0]      accu,
    output logic [31:0]      xreg,
    output logic             persist
);
    localparam int N_ENT = N_MOTORS * N_COORD;
    localparam int AW    = $clog2(N_ENT);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic cok(input logic [7:0] m, input logic [7:0] c);
        return (int'(m) < N_MOTORS) && (int'(c) < N_COORD);
    endfunction

    function automatic logic [AW-1:0] caddr(input logic [7:0] m, input logic [7:0] c);
        return AW'(int'(m) * N_COORD + int'(c));
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [31:0] accu_r,    accu_nxt;
    logic [31:0] x_r,       x_nxt;
    logic        persist_r, persist_nxt;
    logic        done_r,    done_nxt;
    logic        rv_r,      rv_nxt;
    acp_reply_t  rep_r,     rep_nxt;
    logic        aw_v_r,    aw_v_nxt;
    acp_pwr_t    aw_r,      aw_nxt;
    logic        gw_v_r,    gw_v_nxt;
    acp_pwr_t    gw_r,      gw_nxt;
    logic        nv_v_r,    nv_v_nxt;
    acp_coord_t  nv_r,      nv_nxt;
    logic [31:0] coord_r [N_ENT];

    // ------------------------------------------------------------------
    // datagram receiver and calculate unit
    // ------------------------------------------------------------------
    acp_cmd_t    dg_cmd;
    logic        dg_valid;
    logic        dg_ok;
    acp_cmd_t    cmd;
    logic        host_v;
    logic        prog_take;
    logic        exec_v;
    logic [31:0] alu_accu;
    logic [31:0] alu_x;
    logic        alu_ok;
    logic        sel_ok;
    logic [31:0] gco_val;
    logic [7:0]  status;
    logic [31:0] rval;
    logic        cw_en;
    logic [AW-1:0] cw_addr;
    logic [31:0] cw_data;

    acp_rx #(
        .MODULE_ADDR (MODULE_ADDR)
    ) u_rx (
        .clk      (clk),
        .rst_n    (rst_n),
        .rx_valid (rx_valid),
        .rx_byte  (rx_byte),
        .dg_cmd   (dg_cmd),
        .dg_valid (dg_valid),
        .dg_ok    (dg_ok)
    );

    // motor and value fields do not reach the calculate unit
    acp_alu u_alu (
        .op       (cmd.ctype),
        .accu_in  (accu_r),
        .x_in     (x_r),
        .accu_out (alu_accu),
        .x_out    (alu_x),
        .op_ok    (alu_ok)
    );

    // ------------------------------------------------------------------
    // command selection: host datagrams win, program waits
    // ------------------------------------------------------------------
    always_comb begin
        host_v    = dg_valid;
        prog_take = prog_valid && !dg_valid && !done_r;
        cmd       = host_v ? dg_cmd : prog_cmd;
        exec_v    = host_v ? dg_ok : prog_take;
        sel_ok    = cok(cmd.motor, cmd.ctype);
        gco_val   = sel_ok ? coord_r[caddr(cmd.motor, cmd.ctype)] : 32'h0;
        done_nxt  = prog_take;
    end

    // ------------------------------------------------------------------
    // execution
    // ------------------------------------------------------------------
    always_comb begin
        accu_nxt    = accu_r;
        x_nxt       = x_r;
        persist_nxt = persist_r;
        rv_nxt      = 1'b0;
        rep_nxt     = rep_r;
        aw_v_nxt    = 1'b0;
        aw_nxt      = aw_r;
        gw_v_nxt    = 1'b0;
        gw_nxt      = gw_r;
        nv_v_nxt    = 1'b0;
        nv_nxt      = nv_r;
        cw_en       = 1'b0;
        cw_addr     = caddr(cmd.motor, cmd.ctype);
        cw_data     = accu_r;
        status      = `ACP_ST_OK;
        rval        = 32'h0;
        if (exec_v) begin
            unique case (cmd.instr)
                `ACP_I_ACCU_COORD: begin
                    if (sel_ok) begin
                        cw_en = 1'b1;
                        // entry zero lives in volatile storage only
                        if (persist_r && cmd.ctype != 8'h00) begin
                            nv_v_nxt = 1'b1;
                            nv_nxt   = '{motor: cmd.motor, index: cmd.ctype, data: accu_r};
                        end
                    end else begin
                        status = `ACP_ST_BAD_VAL;
                    end
                end
                `ACP_I_CALC_X: begin
                    accu_nxt = alu_accu;
                    x_nxt    = alu_x;
                    if (!alu_ok) begin
                        status = `ACP_ST_BAD_VAL;
                    end
                end
                `ACP_I_ACCU_AXIS: begin
                    if (int'(cmd.motor) < N_MOTORS) begin
                        aw_v_nxt = 1'b1;
                        aw_nxt   = '{num: cmd.ctype, bank: cmd.motor, data: accu_r};
                    end else begin
                        status = `ACP_ST_BAD_VAL;
                    end
                end
                `ACP_I_ACCU_GLOB: begin
                    gw_v_nxt = 1'b1;
                    gw_nxt   = '{num: cmd.ctype, bank: cmd.motor, data: accu_r};
                    if (cmd.ctype == `ACP_GP_PERSIST && cmd.motor == `ACP_GP_BANK) begin
                        persist_nxt = (accu_r != 32'h0);
                    end
                end
                `ACP_I_GET_COORD: begin
                    if (!sel_ok) begin
                        status = `ACP_ST_BAD_VAL;
                    end else if (host_v) begin
                        rval = gco_val;
                    end else begin
                        accu_nxt = gco_val;
                    end
                end
                default: status = `ACP_ST_BAD_CMD;
            endcase
        end
        // restore from nonvolatile store when no command writes
        if (!cw_en && nv_ld_valid && nv_ld.index != 8'h00 && cok(nv_ld.motor, nv_ld.index)) begin
            cw_en   = 1'b1;
            cw_addr = caddr(nv_ld.motor, nv_ld.index);
            cw_data = nv_ld.data;
        end
        if (host_v) begin
            rv_nxt        = 1'b1;
            rep_nxt.status = dg_ok ? status : `ACP_ST_BAD_CSUM;
            rep_nxt.value  = dg_ok ? rval : 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            accu_r    <= 32'h0;
            x_r       <= 32'h0;
            persist_r <= 1'b0;
            done_r    <= 1'b0;
            rv_r      <= 1'b0;
            rep_r     <= '0;
            aw_v_r    <= 1'b0;
            aw_r      <= '0;
            gw_v_r    <= 1'b0;
            gw_r      <= '0;
            nv_v_r    <= 1'b0;
            nv_r      <= '0;
        end else begin
            accu_r    <= accu_nxt;
            x_r       <= x_nxt;
            persist_r <= persist_nxt;
            done_r    <= done_nxt;
            rv_r      <= rv_nxt;
            rep_r     <= rep_nxt;
            aw_v_r    <= aw_v_nxt;
            aw_r      <= aw_nxt;
            gw_v_r    <= gw_v_nxt;
            gw_r      <= gw_nxt;
            nv_v_r    <= nv_v_nxt;
            nv_r      <= nv_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < N_ENT; i++) begin
                coord_r[i] <= 32'h0;
            end
        end else if (cw_en) begin
            coord_r[cw_addr] <= cw_data;
        end
    end

    assign prog_done     = done_r;
    assign reply_valid   = rv_r;
    assign reply         = rep_r;
    assign axis_wr_valid = aw_v_r;
    assign axis_wr       = aw_r;
    assign glob_wr_valid = gw_v_r;
    assign glob_wr       = gw_r;
    assign nv_wr_valid   = nv_v_r;
    assign nv_wr         = nv_r;
    assign accu          = accu_r;
    assign xreg          = x_r;
    assign persist       = persist_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic calc_v;
    assign calc_v = exec_v && cmd.instr == `ACP_I_CALC_X;

    property p_aco;
        exec_v && cmd.instr == `ACP_I_ACCU_COORD && sel_ok
            |=> coord_r[$past(cw_addr)] == $past(accu_r);
    endproperty
    a_aco: assert property (p_aco) else $error("coordinate not loaded");

    property p_nv_persist;
        nv_wr_valid |-> $past(persist_r) && $past(exec_v);
    endproperty
    a_nv_persist: assert property (p_nv_persist) else $error("nv write while volatile");

    property p_nv_zero;
        nv_wr_valid |-> nv_wr.index != 8'h00;
    endproperty
    a_nv_zero: assert property (p_nv_zero) else $error("entry zero sent to nv");

    property p_ok;
        host_v && dg_ok && calc_v && alu_ok
            |=> reply_valid && reply.status == `ACP_ST_OK && reply.value == 32'h0;
    endproperty
    a_ok: assert property (p_ok) else $error("missing ok reply");

    property p_add;
        calc_v && cmd.ctype == `ACP_OP_ADD |=> accu_r == $past(accu_r) + $past(x_r);
    endproperty
    a_add: assert property (p_add) else $error("add result wrong");

    property p_not;
        calc_v && cmd.ctype == `ACP_OP_NOT
            |=> x_r == ~$past(x_r) && accu_r == $past(accu_r);
    endproperty
    a_not: assert property (p_not) else $error("invert result wrong");

    property p_swap;
        calc_v && cmd.ctype == `ACP_OP_SWAP
            |=> accu_r == $past(x_r) && x_r == $past(accu_r);
    endproperty
    a_swap: assert property (p_swap) else $error("swap result wrong");

    property p_aap;
        exec_v && cmd.instr == `ACP_I_ACCU_AXIS && int'(cmd.motor) < N_MOTORS
            |=> axis_wr_valid && axis_wr.data == $past(accu_r) && axis_wr.num == $past(cmd.ctype);
    endproperty
    a_aap: assert property (p_aap) else $error("axis parameter write wrong");

    property p_agp;
        exec_v && cmd.instr == `ACP_I_ACCU_GLOB
            |=> glob_wr_valid && glob_wr.data == $past(accu_r) && glob_wr.bank == $past(cmd.motor);
    endproperty
    a_agp: assert property (p_agp) else $error("global parameter write wrong");

    property p_gco_direct;
        host_v && dg_ok && cmd.instr == `ACP_I_GET_COORD && sel_ok
            |=> accu_r == $past(accu_r) && reply.value == $past(gco_val);
    endproperty
    a_gco_direct: assert property (p_gco_direct) else $error("direct read changed accu");

    c_aco_host: cover property (host_v && dg_ok && cmd.instr == `ACP_I_ACCU_COORD);
    c_calc_prog: cover property (prog_take && calc_v ##1 prog_done);
    c_gco_prog: cover property (prog_take && cmd.instr == `ACP_I_GET_COORD && sel_ok);
    c_bad_csum: cover property (dg_valid && !dg_ok);
endmodule

// [verification/acp_host.sv]
// host model that sends command datagrams over the byte link
`timescale 1ns/10ps

module acp_host
    import acp_pkg::*;
#(
    parameter logic [7:0] MODULE_ADDR = 8'h01
) (
    // clock
    input  wire logic clk,
    // byte link
    output logic       rx_valid,
    output logic [7:0] rx_byte
);
    initial begin
        rx_valid = 1'b0;
        rx_byte  = 8'h00;
    end

    // ------------------------------------------------------------------
    // one datagram, bytes back to back; bad forces a wrong checksum
    // ------------------------------------------------------------------
    task automatic send(input acp_cmd_t c, input logic bad);
        logic [7:0] b [9];
        logic [7:0] s;
        b[0] = MODULE_ADDR;
        {b[1], b[2], b[3], b[4], b[5], b[6], b[7]} = c;
        s = 8'h00;
        for (int i = 0; i < 8; i++) begin
            s = s + b[i];
        end
        b[8] = bad ? ~s : s;
        for (int i = 0; i < 9; i++) begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_byte  = b[i];
        end
        @(negedge clk);
        rx_valid = 1'b0;
        // released line shows no stale byte
        rx_byte  = ~rx_byte;
    endtask
endmodule

// [verification/tb_top.sv]
// self-checking bench for the command executor
`timescale 1ns/10ps
`include "acp_defines.svh"

module tb_top;
    import acp_pkg::*;

    // ------------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------------
    logic       clk, rst_n, rx_valid, prog_valid, prog_done, reply_valid, persist;
    logic       axis_wr_valid, glob_wr_valid, nv_wr_valid, nv_ld_valid;
    logic [7:0] rx_byte;
    logic [31:0] accu, xreg;
    acp_cmd_t   prog_cmd;
    acp_reply_t reply;
    acp_pwr_t   axis_wr, glob_wr;
    acp_coord_t nv_wr, nv_ld;
    int         failures, checks_done, m_a, m_x, m_c;

    acp_top u_acp_top (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .prog_valid(prog_valid), .prog_cmd(prog_cmd), .prog_done(prog_done),
        .reply_valid(reply_valid), .reply(reply), .axis_wr_valid(axis_wr_valid),
        .axis_wr(axis_wr), .glob_wr_valid(glob_wr_valid), .glob_wr(glob_wr),
        .nv_wr_valid(nv_wr_valid), .nv_wr(nv_wr), .nv_ld_valid(nv_ld_valid),
        .nv_ld(nv_ld), .accu(accu), .xreg(xreg), .persist(persist));
    acp_host u_acp_host (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("failures %0d checks_done %0d", failures, checks_done);
        if (failures == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic prog(input logic [7:0] i, t, m, input logic [31:0] v);
        int n;
        @(negedge clk);
        prog_valid = 1'b1;
        prog_cmd   = {i, t, m, v};
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (prog_done !== 1'b1 && n < 20);
        chk(prog_done, 1'b1);
        @(negedge clk);
        prog_valid = 1'b0;
    endtask

    task automatic host(input logic [7:0] i, t, m, input logic [31:0] v, input logic bad);
        int n;
        u_acp_host.send({i, t, m, v}, bad);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (reply_valid !== 1'b1 && n < 20);
        chk(reply_valid, 1'b1);
        chk(reply.status, bad ? `ACP_ST_BAD_CSUM : `ACP_ST_OK);
    endtask

    task automatic load_accu(input int k, input int v);
        @(negedge clk);
        nv_ld_valid = 1'b1;
        nv_ld       = {8'h00, k[7:0], v};
        @(negedge clk);
        nv_ld_valid = 1'b0;
        prog(`ACP_I_GET_COORD, k[7:0], 8'h00, $urandom);
        m_a = v;
        chk(accu, m_a);
    endtask

    function automatic void model_calc(input int t);
        int s;
        s = m_a;
        case (t)
            0: m_a = m_a + m_x;
            1: m_a = m_a - m_x;
            2: m_a = m_a * m_x;
            3: m_a = m_a / m_x;
            4: m_a = m_a % m_x;
            5: m_a = m_a & m_x;
            6: m_a = m_a | m_x;
            7: m_a = m_a ^ m_x;
            8: m_x = ~m_x;
            9: m_x = m_a;
            default: begin
                m_a = m_x;
                m_x = s;
            end
        endcase
    endfunction

    // ------------------------------------------------------------------
    // clock, watchdog and test sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #1000000;
        failures++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h8dbb9dcb));
        rst_n       = 1'b0;
        prog_valid  = 1'b0;
        prog_cmd    = '0;
        nv_ld_valid = 1'b0;
        nv_ld       = '0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk(accu | xreg | 32'(persist), 32'h0);
        for (int t = 0; t <= 10; t++) begin
            load_accu(1, $urandom_range(1, 999));
            prog(`ACP_I_CALC_X, `ACP_OP_LOAD, 8'h00, 0);
            m_x = m_a;
            load_accu(2, $urandom);
            if (t[0]) begin
                host(`ACP_I_CALC_X, t[7:0], 8'($urandom), $urandom, 1'b0);
            end else begin
                prog(`ACP_I_CALC_X, t[7:0], 8'($urandom), $urandom);
            end
            model_calc(t);
            chk(accu, m_a);
            chk(xreg, m_x);
        end
        load_accu(3, $urandom | 1);
        m_c = m_a;
        host(`ACP_I_ACCU_COORD, 8'h05, 8'h00, $urandom, 1'b0);
        chk(nv_wr_valid, 1'b0);
        load_accu(4, $urandom);
        host(`ACP_I_GET_COORD, 8'h05, 8'h00, 0, 1'b0);
        chk(reply.value, m_c);
        chk(accu, m_a);
        load_accu(6, $urandom | 1);
        host(`ACP_I_ACCU_GLOB, `ACP_GP_PERSIST, `ACP_GP_BANK, 0, 1'b0);
        chk({glob_wr_valid, glob_wr.num, glob_wr.bank}, {1'b1, `ACP_GP_PERSIST, 8'h00});
        chk(glob_wr.data, m_a);
        chk(persist, 1'b1);
        host(`ACP_I_ACCU_COORD, 8'h00, 8'h00, 0, 1'b0);
        chk(nv_wr_valid, 1'b0);
        host(`ACP_I_ACCU_COORD, 8'h14, 8'h00, 0, 1'b0);
        chk({nv_wr_valid, nv_wr.motor, nv_wr.index}, {1'b1, 8'h00, 8'h14});
        chk(nv_wr.data, m_a);
        host(`ACP_I_GET_COORD, 8'h14, 8'h00, 0, 1'b0);
        chk(reply.value, m_a);
        prog(`ACP_I_ACCU_AXIS, 8'h07, 8'h00, $urandom);
        chk({axis_wr_valid, axis_wr.num, axis_wr.bank}, {1'b1, 8'h07, 8'h00});
        chk(axis_wr.data, m_a);
        prog(`ACP_I_ACCU_GLOB, 8'h2a, 8'h02, 0);
        chk({glob_wr_valid, glob_wr.num, glob_wr.bank}, {1'b1, 8'h2a, 8'h02});
        chk(glob_wr.data, m_a);
        host(`ACP_I_CALC_X, `ACP_OP_ADD, 8'h00, 0, 1'b1);
        chk(accu, m_a);
        print_verdict();
    end
endmodule
